// *** hdl/tfo_flag_cell.sv ***
// tfo_flag_cell: one sticky interrupt flag with hardware set and two clear paths.
// assumes all inputs are one-cycle pulses synchronous to ref_clk.
`timescale 1ns/1ps
module tfo_flag_cell #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic set_evt,
  input wire logic sw_clr,
  input wire logic vec_clr,
  output logic flag_q
);

  logic flag_d;

  // set wins so an event landing on a clear is never lost
  assign flag_d = set_evt | (flag_q & ~sw_clr & ~vec_clr);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_q <= RESET_VAL;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule : tfo_flag_cell

// *** hdl/tfo_pkg.sv ***
// tfo_pkg: constants and carrier types for the timer compare-output and flag block.
// assumes a 32-bit AXI4-Lite register bus and an external 8-bit counter core.
package tfo_pkg;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] TFO_OFS_CTRL  = 8'h00;
  localparam logic [7:0] TFO_OFS_CMP   = 8'h04;
  localparam logic [7:0] TFO_OFS_IEN   = 8'h08;
  localparam logic [7:0] TFO_OFS_FLAGS = 8'h0c;
  localparam logic [7:0] TFO_OFS_STAT  = 8'h10;

  // ==========================================================================
  // field positions
  localparam int TFO_CTRL_WGM_LSB = 0;
  localparam int TFO_CTRL_COM_LSB = 4;
  localparam int TFO_BIT_OVF = 0;
  localparam int TFO_BIT_CMP = 1;
  localparam int TFO_STAT_PIN = 0;
  localparam int TFO_STAT_OE = 1;
  localparam int TFO_STAT_IRQ = 2;

  // ==========================================================================
  // reset values
  localparam logic [1:0] TFO_WGM_RST = 2'h0;
  localparam logic [1:0] TFO_COM_RST = 2'h0;
  localparam logic [7:0] TFO_CMP_RST = 8'h00;
  localparam logic [1:0] TFO_IEN_RST = 2'h0;
  localparam logic TFO_FLAG_RST = 1'b0;

  // ==========================================================================
  // waveform and compare-output encodings
  localparam logic [1:0] TFO_WGM_NORMAL = 2'h0;
  localparam logic [1:0] TFO_WGM_PHASE = 2'h1;
  localparam logic [1:0] TFO_WGM_CTC = 2'h2;
  localparam logic [1:0] TFO_WGM_FAST = 2'h3;
  localparam logic [1:0] TFO_COM_OFF = 2'h0;
  localparam logic [1:0] TFO_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TFO_COM_CLEAR = 2'h2;
  localparam logic [1:0] TFO_COM_SET = 2'h3;
  localparam logic [7:0] TFO_PWM_TOP = 8'hff;

  // ==========================================================================
  // bus responses
  localparam logic [1:0] TFO_RESP_OKAY = 2'h0;
  localparam logic [1:0] TFO_RESP_DECERR = 2'h3;

  typedef struct packed {
    logic [1:0] compare_output_mode;
    logic [1:0] waveform_mode_select;
  } tfo_ctrl_t;

  // counter core status, all synchronous to ref_clk
  typedef struct packed {
    logic [7:0] value;
    logic tick;
    logic down;
    logic at_top;
    logic at_bottom;
    logic wrap;
  } tfo_cnt_t;

endpackage : tfo_pkg

// *** hdl/tfo_timer_out.sv ***
// tfo_timer_out: compare-output waveform, overflow/compare flags and AXI4-Lite registers.
// assumes an external counter core drives cnt with one-cycle event pulses,
// and the cpu drives the global enable and vector-taken pulses.
`timescale 1ns/1ps

module tfo_timer_out
  import tfo_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire tfo_cnt_t cnt,
  input wire logic global_irq_enable,
  input wire logic ovf_vector_taken,
  input wire logic cmp_vector_taken,
  output logic compare_output_pin,
  output logic compare_output_oe,
  output logic ovf_irq_req,
  output logic cmp_irq_req,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================================
  // register state
  tfo_ctrl_t ctrl_q;
  logic [7:0] compare_value_reg_q;
  logic overflow_irq_enable_q;
  logic compare_irq_enable_q;
  logic overflow_flag;
  logic compare_match_flag;

  // ==========================================================================
  // write channel: address and data are taken in either order
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] wr_addr_q;
  logic [31:0] wr_data_q;
  logic [3:0] wr_strb_q;
  logic aw_fire;
  logic w_fire;
  logic wr_do;
  logic wr_lane0;
  logic wr_hit_ctrl;
  logic wr_hit_cmp;
  logic wr_hit_ien;
  logic wr_hit_flags;
  logic wr_mapped;

  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire = s_axi_wvalid & s_axi_wready;
  assign wr_do = aw_held_q & w_held_q & ~s_axi_bvalid;
  assign wr_lane0 = wr_do & wr_strb_q[0];
  assign wr_hit_ctrl = wr_addr_q == TFO_OFS_CTRL;
  assign wr_hit_cmp = wr_addr_q == TFO_OFS_CMP;
  assign wr_hit_ien = wr_addr_q == TFO_OFS_IEN;
  assign wr_hit_flags = wr_addr_q == TFO_OFS_FLAGS;
  assign wr_mapped = wr_hit_ctrl | wr_hit_cmp | wr_hit_ien | wr_hit_flags
                     | (wr_addr_q == TFO_OFS_STAT);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 32'h0000_0000;
      wr_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TFO_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_held_q <= 1'b1;
        wr_addr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held_q <= 1'b1;
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end
      s_axi_awready <= ~aw_held_q & ~aw_fire;
      s_axi_wready <= ~w_held_q & ~w_fire;
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? TFO_RESP_OKAY : TFO_RESP_DECERR;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid) begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        if (s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // software-written registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q.compare_output_mode <= TFO_COM_RST;
      ctrl_q.waveform_mode_select <= TFO_WGM_RST;
      compare_value_reg_q <= TFO_CMP_RST;
      overflow_irq_enable_q <= TFO_IEN_RST[TFO_BIT_OVF];
      compare_irq_enable_q <= TFO_IEN_RST[TFO_BIT_CMP];
    end else if (wr_lane0) begin
      if (wr_hit_ctrl) begin
        ctrl_q.compare_output_mode <= wr_data_q[TFO_CTRL_COM_LSB +: 2];
        ctrl_q.waveform_mode_select <= wr_data_q[TFO_CTRL_WGM_LSB +: 2];
      end
      if (wr_hit_cmp) begin
        compare_value_reg_q <= wr_data_q[7:0];
      end
      if (wr_hit_ien) begin
        overflow_irq_enable_q <= wr_data_q[TFO_BIT_OVF];
        compare_irq_enable_q <= wr_data_q[TFO_BIT_CMP];
      end
    end
  end

  // ==========================================================================
  // compare-output waveform
  logic [1:0] com;
  logic mode_phase;
  logic mode_fast;
  logic mode_pwm;
  logic cmp_match;
  logic top_special;
  logic pin_connected;
  logic pin_act;
  logic pin_val;
  logic pin_d;

  assign com = ctrl_q.compare_output_mode;
  assign mode_phase = ctrl_q.waveform_mode_select == TFO_WGM_PHASE;
  assign mode_fast = ctrl_q.waveform_mode_select == TFO_WGM_FAST;
  assign mode_pwm = mode_phase | mode_fast;
  assign cmp_match = cnt.tick & (cnt.value == compare_value_reg_q);
  // match suppressed; action moved to top
  assign top_special = mode_pwm & com[1] & (compare_value_reg_q == TFO_PWM_TOP);
  // reserved pwm code leaves the pin disconnected, like code 00
  assign pin_connected = mode_pwm ? com[1] : (com != TFO_COM_OFF);

  always_comb begin
    pin_act = 1'b0;
    pin_val = compare_output_pin;
    if (!mode_pwm) begin
      pin_act = cmp_match;
      case (com)
        TFO_COM_TOGGLE: pin_val = ~compare_output_pin;
        TFO_COM_CLEAR: pin_val = 1'b0;
        TFO_COM_SET: pin_val = 1'b1;
        default: pin_act = 1'b0;
      endcase
    end else if (com[1]) begin
      if (top_special) begin
        pin_act = cnt.at_top;
        pin_val = ~com[0];
      end else if (mode_fast) begin
        // a match at bottom wins so compare value zero holds the pin at the match level
        pin_act = cmp_match | cnt.at_bottom;
        pin_val = cmp_match ? com[0] : ~com[0];
      end else begin
        pin_act = cmp_match;
        pin_val = cnt.down ? ~com[0] : com[0];
      end
    end
  end

  assign pin_d = (pin_connected & pin_act) ? pin_val : compare_output_pin;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      compare_output_pin <= 1'b0;
      compare_output_oe <= 1'b0;
    end else begin
      compare_output_pin <= pin_d;
      compare_output_oe <= pin_connected;
    end
  end

  // ==========================================================================
  // flags and interrupt requests
  logic ovf_evt;
  logic clr_ovf_sw;
  logic clr_cmp_sw;

  // phase-correct overflow marks the turn at bottom, not a wrap
  assign ovf_evt = mode_phase ? cnt.at_bottom : cnt.wrap;
  assign clr_ovf_sw = wr_lane0 & wr_hit_flags & wr_data_q[TFO_BIT_OVF];
  assign clr_cmp_sw = wr_lane0 & wr_hit_flags & wr_data_q[TFO_BIT_CMP];

  tfo_flag_cell #(
    .RESET_VAL(TFO_FLAG_RST)
  ) u_ovf_flag (
    .ref_clk(ref_clk),
    .rst(rst),
    .set_evt(ovf_evt),
    .sw_clr(clr_ovf_sw),
    .vec_clr(ovf_vector_taken),
    .flag_q(overflow_flag)
  );

  tfo_flag_cell #(
    .RESET_VAL(TFO_FLAG_RST)
  ) u_cmp_flag (
    .ref_clk(ref_clk),
    .rst(rst),
    .set_evt(cmp_match),
    .sw_clr(clr_cmp_sw),
    .vec_clr(cmp_vector_taken),
    .flag_q(compare_match_flag)
  );

  logic ovf_req_d;
  logic cmp_req_d;

  assign ovf_req_d = global_irq_enable & overflow_irq_enable_q & overflow_flag;
  assign cmp_req_d = global_irq_enable & compare_irq_enable_q & compare_match_flag;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ovf_irq_req <= 1'b0;
      cmp_irq_req <= 1'b0;
      irq <= 1'b0;
    end else begin
      ovf_irq_req <= ovf_req_d;
      cmp_irq_req <= cmp_req_d;
      irq <= ovf_req_d | cmp_req_d;
    end
  end

  // ==========================================================================
  // read channel: one read at a time, answer one cycle after acceptance
  logic ar_fire;
  logic [31:0] rd_mux;
  logic [31:0] rd_ctrl;
  logic [31:0] rd_ien;
  logic [31:0] rd_flags;
  logic [31:0] rd_stat;
  logic rd_mapped;

  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign rd_ctrl = {26'h0, com, 2'h0, ctrl_q.waveform_mode_select};
  assign rd_ien = {30'h0, compare_irq_enable_q, overflow_irq_enable_q};
  assign rd_flags = {30'h0, compare_match_flag, overflow_flag};
  assign rd_stat = {29'h0, irq, compare_output_oe, compare_output_pin};
  assign rd_mapped = (s_axi_araddr == TFO_OFS_CTRL) | (s_axi_araddr == TFO_OFS_CMP)
                     | (s_axi_araddr == TFO_OFS_IEN) | (s_axi_araddr == TFO_OFS_FLAGS)
                     | (s_axi_araddr == TFO_OFS_STAT);
  assign rd_mux = (s_axi_araddr == TFO_OFS_CTRL) ? rd_ctrl :
                  (s_axi_araddr == TFO_OFS_CMP) ? {24'h0, compare_value_reg_q} :
                  (s_axi_araddr == TFO_OFS_IEN) ? rd_ien :
                  (s_axi_araddr == TFO_OFS_FLAGS) ? rd_flags :
                  (s_axi_araddr == TFO_OFS_STAT) ? rd_stat : 32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= TFO_RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_mapped ? TFO_RESP_OKAY : TFO_RESP_DECERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : tfo_timer_out

// *** tb/tfo_chk_properties.sv ***
// tfo_chk: port-level assertions for tfo_timer_out.
// assumes one clock domain, rst synchronous active high.
`timescale 1ns/1ps
module tfo_chk
  import tfo_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire tfo_cnt_t cnt,
  input wire logic global_irq_enable,
  input wire logic ovf_vector_taken,
  input wire logic cmp_vector_taken,
  input wire logic compare_output_pin,
  input wire logic compare_output_oe,
  input wire logic ovf_irq_req,
  input wire logic cmp_irq_req,
  input wire logic irq,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid
);
  // ==========================================================================
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_irq_is_or: assert property (irq == (ovf_irq_req | cmp_irq_req))
    else $error("irq differs from request or");
  a_ovf_needs_global: assert property (ovf_irq_req |-> $past(global_irq_enable))
    else $error("overflow request without global enable");
  a_cmp_needs_global: assert property (cmp_irq_req |-> $past(global_irq_enable))
    else $error("compare request without global enable");
  a_global_off: assert property (!global_irq_enable |=> !irq)
    else $error("irq while global enable low");
  a_ovf_vec_clear: assert property (ovf_vector_taken && !cnt.wrap && !cnt.at_bottom
    |-> ##2 !ovf_irq_req) else $error("overflow request after vector");
  a_cmp_vec_clear: assert property (cmp_vector_taken && !cnt.tick
    |-> ##2 !cmp_irq_req) else $error("compare request after vector");
  // pin only moves on counter events, never on its own
  a_pin_hold: assert property (!(cnt.tick | cnt.at_top | cnt.at_bottom)
    |=> $stable(compare_output_pin)) else $error("pin moved without event");
  a_rst_quiet: assert property (disable iff (1'b0) rst
    |=> !compare_output_oe && !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
endmodule : tfo_chk

bind tfo_timer_out tfo_chk i_chk (.ref_clk(ref_clk), .rst(rst), .cnt(cnt),
  .global_irq_enable(global_irq_enable), .ovf_vector_taken(ovf_vector_taken),
  .cmp_vector_taken(cmp_vector_taken), .compare_output_pin(compare_output_pin),
  .compare_output_oe(compare_output_oe), .ovf_irq_req(ovf_irq_req),
  .cmp_irq_req(cmp_irq_req), .irq(irq), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_rvalid(s_axi_rvalid));

// *** tb/tfo_load.sv ***
// tfo_load: load on the compare output pin.
// assumes a pull-up holds the line while the timer lets go.
`timescale 1ns/1ps
module tfo_load (
  input wire logic compare_output_pin,
  input wire logic compare_output_oe,
  output logic line
);
  assign line = compare_output_oe ? compare_output_pin : 1'b1;
endmodule : tfo_load

// *** tb/tfo_tb.sv ***
// testbench: self-checking bench for tfo_timer_out.
// assumes the load model and the bound checker sit beside it.
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin err_total++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module testbench;
  import tfo_pkg::*;
  logic ref_clk = 0, rst = 1, gie = 0, ovt = 0, cvt = 0;
  tfo_cnt_t cnt = '0;
  logic pin, oe, oreq, creq, irq, line, awr, wr, bv, arr, rv, p;
  logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd, v;
  logic [1:0] bresp, rresp, r, c;
  logic [9:0] t;
  logic [7:0] ofs [5] = '{TFO_OFS_CTRL, TFO_OFS_CMP, TFO_OFS_IEN, TFO_OFS_FLAGS, TFO_OFS_STAT};
  // {mode, com, tick down top bottom wrap, expected pin}
  logic [9:0] tab [11] = '{{4'he, 5'h10, 1'b0}, {4'he, 5'h02, 1'b1}, {4'he, 5'h10, 1'b0},
    {4'hf, 5'h10, 1'b1}, {4'hf, 5'h02, 1'b0}, {4'h6, 5'h10, 1'b0}, {4'h6, 5'h18, 1'b1},
    {4'h6, 5'h10, 1'b0}, {4'h7, 5'h10, 1'b1}, {4'h7, 5'h02, 1'b1}, {4'h7, 5'h18, 1'b0}};
  int err_total = 0, comparisons = 0, seed = 97;
  always #25 ref_clk = ~ref_clk;
  tfo_timer_out i_tfo_timer_out (.ref_clk(ref_clk), .rst(rst), .cnt(cnt),
    .global_irq_enable(gie), .ovf_vector_taken(ovt), .cmp_vector_taken(cvt),
    .compare_output_pin(pin), .compare_output_oe(oe), .ovf_irq_req(oreq),
    .cmp_irq_req(creq), .irq(irq), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr));
  tfo_load i_tfo_load (.compare_output_pin(pin), .compare_output_oe(oe), .line(line));
  // ==========================================================================
  // bus and counter drivers
  // no own limit: only the watchdog ends a wait for the answer
  task automatic wrt(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    br <= 1;
    do begin
      @(posedge ref_clk);
      if (awr) awv <= 0;
      if (wr) wv <= 0;
    end while (bv !== 1'b1);
    r = bresp;
    br <= 0;
  endtask : wrt
  task automatic rdt(input logic [7:0] a);
    @(posedge ref_clk);
    ara <= a;
    arv <= 1;
    rr <= 1;
    do begin
      @(posedge ref_clk);
      if (arr) arv <= 0;
    end while (rv !== 1'b1);
    v = rd;
    r = rresp;
    rr <= 0;
  endtask : rdt
  // one event cycle, then settle so the pin is readable
  task automatic ev(input logic [7:0] val, input logic [4:0] f);
    @(posedge ref_clk);
    cnt <= {val, f};
    @(posedge ref_clk);
    cnt <= {val, 1'b0, f[3], 3'h0};
    @(posedge ref_clk);
  endtask : ev
  function automatic logic np(input logic [1:0] cm, input logic pv);
    case (cm)
      TFO_COM_TOGGLE: np = ~pv;
      TFO_COM_CLEAR: np = 1'b0;
      TFO_COM_SET: np = 1'b1;
      default: np = pv;
    endcase
  endfunction : np
  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] cm);
    ctl = {26'h0, cm, 2'h0, m};
  endfunction : ctl
  task close_out;
    $display("counts: %0d compared, %0d wrong", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  // ==========================================================================
  // tests
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 0;
    for (int i = 0; i < 5; i++) begin
      rdt(ofs[i]);
      `CHK("reset value", 32'h0, v)
    end
    rdt(8'h40);
    `CHK("rresp", TFO_RESP_DECERR, r)
    wrt(8'h40, 32'h1);
    `CHK("bresp", TFO_RESP_DECERR, r)
    $display("test regs done");
    wrt(TFO_OFS_CMP, 32'h10);
    p = 0;
    for (int i = 0; i < 24; i++) begin
      c = $random(seed);
      wrt(TFO_OFS_CTRL, ctl(i[0] ? TFO_WGM_CTC : TFO_WGM_NORMAL, c));
      v = $random(seed);
      ev(v[0] ? 8'h10 : {v[7:1], 1'b1}, 5'h10);
      if (v[0]) p = np(c, p);
      `CHK("oe", c != 2'h0, oe)
      if (c != 2'h0) `CHK("pin", p, pin)
      else `CHK("line", 1'b1, line)
    end
    $display("test nonpwm done");
    for (int i = 0; i < 11; i++) begin
      t = tab[i];
      wrt(TFO_OFS_CTRL, ctl(t[9:8], t[7:6]));
      ev(8'h10, t[5:1]);
      `CHK("pwm pin", t[0], pin)
    end
    for (int i = 0; i < 2; i++) begin
      wrt(TFO_OFS_CTRL, ctl(i[0] ? TFO_WGM_FAST : TFO_WGM_PHASE, TFO_COM_TOGGLE));
      // oe is loaded one edge after the write; the event cycles let it settle
      ev(8'h10, 5'h12);
      `CHK("reserved oe", 1'b0, oe)
      `CHK("reserved pin", 1'b0, pin)
    end
    wrt(TFO_OFS_CTRL, ctl(TFO_WGM_PHASE, TFO_COM_CLEAR));
    ev(8'h10, 5'h10);
    wrt(TFO_OFS_CMP, 32'hff);
    ev(8'hff, 5'h18);
    `CHK("top match ignored", 1'b0, pin)
    ev(8'hff, 5'h14);
    `CHK("top action", 1'b1, pin)
    wrt(TFO_OFS_CTRL, ctl(TFO_WGM_FAST, TFO_COM_SET));
    ev(8'hff, 5'h14);
    `CHK("fast top action", 1'b0, pin)
    $display("test pwm done");
    rdt(TFO_OFS_FLAGS);
    `CHK("flags", 32'h3, v)
    wrt(TFO_OFS_FLAGS, 32'h0);
    rdt(TFO_OFS_FLAGS);
    `CHK("flags w0", 32'h3, v)
    wrt(TFO_OFS_FLAGS, 32'h2);
    rdt(TFO_OFS_FLAGS);
    `CHK("flags w1 cmp", 32'h1, v)
    wrt(TFO_OFS_FLAGS, 32'h1);
    ev(8'h00, 5'h01);
    rdt(TFO_OFS_FLAGS);
    `CHK("fast wrap", 32'h1, v)
    wrt(TFO_OFS_FLAGS, 32'h1);
    wrt(TFO_OFS_CTRL, ctl(TFO_WGM_PHASE, TFO_COM_OFF));
    ev(8'h00, 5'h01);
    rdt(TFO_OFS_FLAGS);
    `CHK("phase wrap", 32'h0, v)
    ev(8'h00, 5'h02);
    ev(8'hff, 5'h10);
    rdt(TFO_OFS_FLAGS);
    `CHK("phase bottom", 32'h3, v)
    $display("test flags done");
    wrt(TFO_OFS_IEN, 32'h3);
    repeat (2) @(posedge ref_clk);
    `CHK("irq gie off", 1'b0, irq)
    gie <= 1;
    repeat (3) @(posedge ref_clk);
    `CHK("ovf req", 1'b1, oreq)
    `CHK("cmp req", 1'b1, creq)
    wrt(TFO_OFS_IEN, 32'h2);
    repeat (2) @(posedge ref_clk);
    `CHK("ovf masked", 1'b0, oreq)
    `CHK("irq", 1'b1, irq)
    cvt <= 1;
    @(posedge ref_clk);
    cvt <= 0;
    repeat (2) @(posedge ref_clk);
    `CHK("cmp vec", 1'b0, creq)
    ovt <= 1;
    @(posedge ref_clk);
    ovt <= 0;
    rdt(TFO_OFS_FLAGS);
    `CHK("vec flags", 32'h0, v)
    $display("test irq done");
    close_out;
  end
  initial begin
    repeat (6000) @(posedge ref_clk);
    err_total++;
    close_out;
  end
endmodule : testbench
